//--- hdl/vint_regs.vh
// Register offsets, field positions and constants of the interrupt unit
`ifndef VINT_REGS_VH
`define VINT_REGS_VH
// APB byte offsets
`define OFS_MASK        12'h000
`define OFS_CONTROL     12'h004
`define OFS_FORCE_CLEAR 12'h008
`define OFS_ARITH       12'h00C
`define OFS_MODE        12'h010
`define OFS_STATUS      12'h014
`define OFS_COMMAND     12'h018
// Control register fields
`define CTL_EDGE_LO     0
`define CTL_EDGE_HI     2
`define CTL_NEST_BIT    4
`define CTL_ALT_BIT     5
// Force/clear fields: force in [13:8], clear in [5:0]
`define FC_FORCE_LO     8
// Command register bits
`define CMD_RTI_BIT     0
// Vector map
`define VEC_RESET       14'h0000
`define VEC_BASE        14'h0004
`define VEC_STEP        14'h0004
`define NUM_SRC         6
`define STACK_DEPTH     7
`define MASK_RESET      6'h00
`define CONTROL_RESET   6'h00
// Least reset hold at power-up, in clock cycles
`define RESET_HOLD_CYC  2000
`endif

//--- hdl/vint_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module vint_sync #(
	parameter WIDTH = 3
) (
	input  wire             CLK,
	input  wire             RST,
	input  wire [WIDTH-1:0] PIN,
	output reg  [WIDTH-1:0] LEVEL
);
	reg [WIDTH-1:0] stage_a;
	reg [WIDTH-1:0] stage_b;
	reg [WIDTH-1:0] stage_c;
	integer i;
	// Pins are active low, so idle state is all ones
	always @(posedge CLK) begin
		if (RST) begin
			stage_a <= {WIDTH{1'b1}};
			stage_b <= {WIDTH{1'b1}};
			stage_c <= {WIDTH{1'b1}};
			LEVEL   <= {WIDTH{1'b1}};
		end else begin
			stage_a <= PIN;
			stage_b <= stage_a;
			stage_c <= stage_b;
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (stage_b[i] == stage_c[i]) begin
					LEVEL[i] <= stage_c[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- hdl/vint_unit.v
// Prioritized vectored interrupt unit with status stack and APB registers
`timescale 1ns/10ps
`default_nettype none
`include "vint_regs.vh"
module vint_unit (
	input  wire        CLK,
	input  wire        RST,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	input  wire        EXT_INT_REQ_TWO_N,
	input  wire        RX_FRAME_SYNC_B,
	input  wire        TX_FRAME_SYNC_B,
	input  wire        RX_DATA_B,
	output wire        TX_DATA_B,
	output wire        FLAG_INPUT,
	input  wire        FLAG_OUTPUT,
	input  wire        SERIAL_B_ALT,
	input  wire        SERIAL_A_TX_INT,
	input  wire        SERIAL_A_RX_INT,
	input  wire        SERIAL_B_TX_INT,
	input  wire        SERIAL_B_RX_INT,
	input  wire        TIMER_INT,
	input  wire        SERIAL_B_TX_DATA,
	input  wire        RTI,
	input  wire        INSN_DONE,
	input  wire        BUS_REQUEST_N,
	input  wire        MEMORY_MAP_SELECT,
	output reg         TAKE,
	output reg  [13:0] VECTOR,
	output reg  [2:0]  ACTIVE_SRC,
	output reg         BOOT_START,
	output reg         FETCH_START
);
	// ==========================================================
	// Helpers
	function [2:0] top_source;
		input [5:0] req;
		integer k;
		begin
			top_source = 3'h7;
			for (k = `NUM_SRC - 1; k >= 0; k = k - 1) begin
				if (req[k]) begin
					top_source = k[2:0];
				end
			end
		end
	endfunction

	function [5:0] onehot;
		input [2:0] idx;
		begin
			onehot = 6'h01 << idx;
		end
	endfunction

	// ==========================================================
	// Pin synchronisers (pins active low)
	wire [2:0] ext_raw;
	wire [2:0] ext_level;
	wire [1:0] sys_level;
	assign ext_raw = {EXT_INT_REQ_TWO_N,
		SERIAL_B_ALT ? TX_FRAME_SYNC_B : 1'b1,
		SERIAL_B_ALT ? RX_FRAME_SYNC_B : 1'b1};
	assign FLAG_INPUT = SERIAL_B_ALT ? RX_DATA_B : 1'b0;
	assign TX_DATA_B  = SERIAL_B_ALT ? FLAG_OUTPUT : SERIAL_B_TX_DATA;

	vint_sync #(.WIDTH(3)) u_sync (
		.CLK   (CLK),
		.RST   (RST),
		.PIN   (ext_raw),
		.LEVEL (ext_level)
	);

	// Bus request and map pins are filtered too; a request reads as
	// pending during reset so boot never starts on an unsettled pin
	vint_sync #(.WIDTH(2)) u_sys_sync (
		.CLK   (CLK),
		.RST   (RST),
		.PIN   ({~BUS_REQUEST_N, ~MEMORY_MAP_SELECT}),
		.LEVEL (sys_level)
	);
	wire bus_req_pend = sys_level[1];
	wire map_low      = sys_level[0];

	// ==========================================================
	// Registers
	reg  [5:0]  interrupt_mask_reg;
	reg  [5:0]  interrupt_control_reg;
	reg  [15:0] arith_status_reg;
	reg  [15:0] mode_status_reg;
	reg  [5:0]  edge_latch;
	reg  [5:0]  force_latch;
	reg  [2:0]  ext_prev;
	reg         booted;
	reg  [2:0]  depth;
	reg  [37:0] stack_mem [0:`STACK_DEPTH-1];
	reg  [2:0]  serv_stack [0:`STACK_DEPTH-1];
	reg  [31:0] rdata;
	reg         rti_sw;

	wire wr_en = PSEL & PENABLE & PWRITE;
	wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
	wire mapped = (PADDR == `OFS_MASK) || (PADDR == `OFS_CONTROL) ||
		(PADDR == `OFS_FORCE_CLEAR) || (PADDR == `OFS_ARITH) ||
		(PADDR == `OFS_MODE) || (PADDR == `OFS_STATUS) ||
		(PADDR == `OFS_COMMAND);
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;
	assign PRDATA  = rdata;

	wire       wr_fc   = wr_en & (PADDR == `OFS_FORCE_CLEAR);
	wire [5:0] clr_bit = wr_fc ? PWDATA[5:0] : 6'h00;
	wire [5:0] frc_bit = wr_fc ? PWDATA[`FC_FORCE_LO+5:`FC_FORCE_LO] :
		6'h00;

	// ==========================================================
	// Request formation
	// Source order: 0 ext two, 1 A tx, 2 A rx, 3 B tx/ext one,
	// 4 B rx/ext zero, 5 timer
	wire [2:0] ext_act  = ~ext_level;
	wire [2:0] ext_rise = ext_act & ~ext_prev;
	wire [2:0] edge_sel =
		interrupt_control_reg[`CTL_EDGE_HI:`CTL_EDGE_LO];
	wire [5:0] ext_map_level = {1'b0, ext_act[0], ext_act[1],
		2'b00, ext_act[2]};
	wire [5:0] ext_map_rise  = {1'b0, ext_rise[0], ext_rise[1],
		2'b00, ext_rise[2]};
	wire [5:0] ext_map_edge  = {1'b0, edge_sel[0], edge_sel[1],
		2'b00, edge_sel[2]};
	wire [5:0] ext_src = {1'b0, SERIAL_B_ALT, SERIAL_B_ALT, 2'b00, 1'b1};
	wire [5:0] int_req = {TIMER_INT,
		~SERIAL_B_ALT & SERIAL_B_RX_INT,
		~SERIAL_B_ALT & SERIAL_B_TX_INT,
		SERIAL_A_RX_INT, SERIAL_A_TX_INT, 1'b0};
	// level sources follow pin, edge sources latched
	wire [5:0] level_req = ext_src & ~ext_map_edge & ext_map_level;
	wire [5:0] pending = edge_latch | force_latch | int_req | level_req;
	// mask gating; reset is not a source here
	wire [5:0] unmasked = pending & interrupt_mask_reg;

	// nesting decides which requests may preempt
	wire       nested   = interrupt_control_reg[`CTL_NEST_BIT];
	wire [2:0] cur_src  = (depth == 3'd0) ? 3'h7 :
		serv_stack[depth - 3'd1];
	wire [5:0] higher   = (cur_src == 3'h7) ? 6'h3F :
		(onehot(cur_src) - 6'h01);
	wire [5:0] eligible = (depth == 3'd0) ? unmasked :
		(nested ? (unmasked & higher) : 6'h00);
	wire [2:0] win      = top_source(eligible);
	wire       take_now = (win != 3'h7) & INSN_DONE & booted &
		(depth < `STACK_DEPTH);
	// A return in a take cycle is dropped; the take goes ahead and the return is lost
	wire       pop      = (RTI | rti_sw) & (depth != 3'd0) & ~take_now;

	// ==========================================================
	// Pending latches
	integer j;
	always @(posedge CLK) begin
		if (RST) begin
			edge_latch  <= 6'h00;
			force_latch <= 6'h00;
			ext_prev    <= 3'b000;
		end else begin
			ext_prev <= ext_act;
			for (j = 0; j < `NUM_SRC; j = j + 1) begin
				// set wins over acknowledge or clear
				if (ext_src[j] & ext_map_edge[j] & ext_map_rise[j]) begin
					edge_latch[j] <= 1'b1;
				end else if (clr_bit[j] |
					(take_now & (win == j[2:0]))) begin
					edge_latch[j] <= 1'b0;
				end
				// force and clear bits per source
				if (frc_bit[j]) begin
					force_latch[j] <= 1'b1;
				end else if (clr_bit[j] |
					(take_now & (win == j[2:0]))) begin
					force_latch[j] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Status stack and register writes
	wire [37:0] top_entry = stack_mem[depth - 3'd1];
	integer s;
	always @(posedge CLK) begin
		if (RST) begin
			// empty stack, all masked, mode cleared
			depth                 <= 3'd0;
			interrupt_mask_reg    <= `MASK_RESET;
			interrupt_control_reg <= `CONTROL_RESET;
			mode_status_reg       <= 16'h0000;
			arith_status_reg      <= 16'h0000;
			TAKE                  <= 1'b0;
			VECTOR                <= `VEC_RESET;
			ACTIVE_SRC            <= 3'h7;
			rti_sw                <= 1'b0;
			for (s = 0; s < `STACK_DEPTH; s = s + 1) begin
				stack_mem[s]  <= 38'h0;
				serv_stack[s] <= 3'h7;
			end
		end else begin
			TAKE   <= 1'b0;
			rti_sw <= wr_en & (PADDR == `OFS_COMMAND) &
				PWDATA[`CMD_RTI_BIT];
			if (wr_en & (PADDR == `OFS_MASK)) begin
				interrupt_mask_reg <= PWDATA[5:0];
			end
			if (wr_en & (PADDR == `OFS_CONTROL)) begin
				interrupt_control_reg <= PWDATA[5:0];
			end
			if (wr_en & (PADDR == `OFS_ARITH)) begin
				arith_status_reg <= PWDATA[15:0];
			end
			if (wr_en & (PADDR == `OFS_MODE)) begin
				mode_status_reg <= PWDATA[15:0];
			end
			if (take_now) begin
				stack_mem[depth]  <= {arith_status_reg,
					mode_status_reg, interrupt_mask_reg};
				serv_stack[depth] <= win;
				depth             <= depth + 3'd1;
				TAKE              <= 1'b1;
				// vector is base plus four words per slot
				VECTOR     <= `VEC_BASE + ({11'h000, win} << 2);
				ACTIVE_SRC <= win;
			end else if (pop) begin
				arith_status_reg   <= top_entry[37:22];
				mode_status_reg    <= top_entry[21:6];
				interrupt_mask_reg <= top_entry[5:0];
				depth              <= depth - 3'd1;
				ACTIVE_SRC         <= (depth == 3'd1) ? 3'h7 :
					serv_stack[depth - 3'd2];
			end
		end
	end

	// ==========================================================
	// Boot start after reset
	always @(posedge CLK) begin
		if (RST) begin
			booted      <= 1'b0;
			BOOT_START  <= 1'b0;
			FETCH_START <= 1'b0;
		end else begin
			BOOT_START  <= 1'b0;
			FETCH_START <= 1'b0;
			// boot once no bus request is pending; boot start only with map low
			if (~booted & ~bus_req_pend) begin
				booted      <= 1'b1;
				BOOT_START  <= map_low;
				FETCH_START <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Read mux; force/clear reads zero (write-only)
	// Captured in the setup cycle so read data comes from a flop and
	// stands through the whole access phase
	always @(posedge CLK) begin
		if (RST) begin
			rdata <= 32'h00000000;
		end else if (rd_setup) begin
			case (PADDR)
			`OFS_MASK:    rdata <= {26'h0, interrupt_mask_reg};
			`OFS_CONTROL: rdata <= {26'h0, interrupt_control_reg};
			`OFS_ARITH:   rdata <= {16'h0, arith_status_reg};
			`OFS_MODE:    rdata <= {16'h0, mode_status_reg};
			`OFS_STATUS:  rdata <= {16'h0, ACTIVE_SRC, 2'b00,
				depth, 2'b00, pending};
			default:      rdata <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- verification/vint_seq_model.sv
// Sequencer-side model: instruction boundaries and returns
`timescale 1ns/10ps
`default_nettype none
module vint_seq_model (
	input  wire logic CLK,
	input  wire logic RST,
	input  wire logic slow,
	input  wire logic ret,
	output var  logic insn_done,
	output var  logic rti
);
	// ==========
	// Slow mode offers a take point only every other cycle
	always @(posedge CLK) begin
		if (RST) begin
			insn_done <= 1'b0;
			rti <= 1'b0;
		end else begin
			insn_done <= slow ? !insn_done : 1'b1;
			rti <= ret;
		end
	end
endmodule
`default_nettype wire

//--- verification/vint_unit_props.sv
// Port-level checks for the interrupt unit
`timescale 1ns/10ps
`default_nettype none
module vint_unit_props (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [11:0] PADDR,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        RX_DATA_B,
	input wire logic        TX_DATA_B,
	input wire logic        FLAG_INPUT,
	input wire logic        FLAG_OUTPUT,
	input wire logic        SERIAL_B_ALT,
	input wire logic        SERIAL_B_TX_DATA,
	input wire logic        INSN_DONE,
	input wire logic        BUS_REQUEST_N,
	input wire logic        MEMORY_MAP_SELECT,
	input wire logic        TAKE,
	input wire logic [13:0] VECTOR,
	input wire logic [2:0]  ACTIVE_SRC,
	input wire logic        BOOT_START,
	input wire logic        FETCH_START
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// ==========
	// Steps of a take and of the boot
	sequence s_take;
		TAKE ##1 !TAKE;
	endsequence
	sequence s_once;
		FETCH_START ##1 !FETCH_START [*8];
	endsequence
	a_take_pulse: assert property (TAKE |-> s_take)
		else $error("take longer than one cycle");
	a_take_cause: assert property (TAKE |-> $past(INSN_DONE))
		else $error("take without instruction boundary");
	a_vec_map: assert property (TAKE |->
		VECTOR == {9'h000, ACTIVE_SRC, 2'h0} + 14'h0004)
		else $error("vector does not match source");
	a_vec_range: assert property (TAKE |-> VECTOR >= 14'h0004 &&
		VECTOR <= 14'h0018 && ACTIVE_SRC != 3'h7)
		else $error("vector outside table");
	a_reset_idle: assert property ($fell(RST) |->
		!TAKE && ACTIVE_SRC == 3'h7)
		else $error("not idle after reset");
	a_boot_gate: assert property (FETCH_START |-> $past(BUS_REQUEST_N))
		else $error("fetch with bus request pending");
	a_boot_map: assert property (BOOT_START |->
		!$past(MEMORY_MAP_SELECT))
		else $error("boot with map select high");
	a_fetch_once: assert property (FETCH_START |-> s_once)
		else $error("fetch start repeated");
	a_flag_alt: assert property (SERIAL_B_ALT |-> FLAG_INPUT == RX_DATA_B
		&& TX_DATA_B == FLAG_OUTPUT)
		else $error("flag pins not routed");
	a_flag_norm: assert property (!SERIAL_B_ALT |-> !FLAG_INPUT
		&& TX_DATA_B == SERIAL_B_TX_DATA)
		else $error("serial data pins not routed");
	a_bus_err: assert property (PSEL && PENABLE && PADDR > 12'h018 |->
		PSLVERR && PREADY)
		else $error("unmapped access not refused");
endmodule
bind vint_unit vint_unit_props u_props (.CLK(CLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.RX_DATA_B(RX_DATA_B), .TX_DATA_B(TX_DATA_B), .FLAG_INPUT(FLAG_INPUT),
	.FLAG_OUTPUT(FLAG_OUTPUT), .SERIAL_B_ALT(SERIAL_B_ALT),
	.SERIAL_B_TX_DATA(SERIAL_B_TX_DATA), .INSN_DONE(INSN_DONE),
	.BUS_REQUEST_N(BUS_REQUEST_N), .MEMORY_MAP_SELECT(MEMORY_MAP_SELECT),
	.TAKE(TAKE), .VECTOR(VECTOR), .ACTIVE_SRC(ACTIVE_SRC),
	.BOOT_START(BOOT_START), .FETCH_START(FETCH_START));
`default_nettype wire

//--- verification/vint_unit_bench.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/10ps
`default_nettype none
`include "vint_regs.vh"
module vint_unit_bench;
	logic        CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
	logic        PWRITE = 1'b0, RX_DATA_B = 1'b0, FLAG_OUTPUT = 1'b1;
	logic        SERIAL_B_ALT = 1'b0, BUS_REQUEST_N = 1'b0;
	logic        slow = 1'b0, ret = 1'b0, err;
	logic        rfs_n = 1'b1, tfs_n = 1'b1;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, q;
	logic        PREADY, PSLVERR, TX_DATA_B, FLAG_INPUT, TAKE, RTI;
	logic        BOOT_START, FETCH_START, INSN_DONE;
	logic [5:0]  lvl = 6'h00;
	logic [13:0] VECTOR, last_vec;
	logic [2:0]  ACTIVE_SRC;
	int          n_mismatch = 0, num_checks = 0, n_take = 0, exp_n = 0;
	int          n_boot = 0, cyc = 0;
	always #2.5 CLK = ~CLK;
	vint_unit u_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_INT_REQ_TWO_N(~lvl[0]),
		.RX_FRAME_SYNC_B(rfs_n), .TX_FRAME_SYNC_B(tfs_n), .RX_DATA_B(RX_DATA_B),
		.TX_DATA_B(TX_DATA_B), .FLAG_INPUT(FLAG_INPUT),
		.FLAG_OUTPUT(FLAG_OUTPUT), .SERIAL_B_ALT(SERIAL_B_ALT),
		.SERIAL_A_TX_INT(lvl[1]), .SERIAL_A_RX_INT(lvl[2]),
		.SERIAL_B_TX_INT(lvl[3]), .SERIAL_B_RX_INT(lvl[4]),
		.TIMER_INT(lvl[5]), .SERIAL_B_TX_DATA(1'b0), .RTI(RTI),
		.INSN_DONE(INSN_DONE), .BUS_REQUEST_N(BUS_REQUEST_N),
		.MEMORY_MAP_SELECT(1'b0), .TAKE(TAKE), .VECTOR(VECTOR),
		.ACTIVE_SRC(ACTIVE_SRC), .BOOT_START(BOOT_START),
		.FETCH_START(FETCH_START));
	vint_seq_model u_seq (.CLK(CLK), .RST(RST), .slow(slow), .ret(ret),
		.insn_done(INSN_DONE), .rti(RTI));
	// ==========
	// Take monitor and hang guard
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (TAKE === 1'b1) begin
			n_take <= n_take + 1;
			last_vec <= VECTOR;
		end
		if (BOOT_START === 1'b1)
			n_boot <= n_boot + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, s);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic take_is(input logic [13:0] v);
		exp_n++;
		repeat (100) if (n_take < exp_n) @(posedge CLK);
		chk("take count", exp_n, n_take);
		chk("vector", {18'h00000, v}, {18'h00000, last_vec});
	endtask
	task automatic idle();
		repeat (10) @(posedge CLK);
		chk("take count", exp_n, n_take);
	endtask
	task automatic back();
		@(posedge CLK);
		ret <= 1'b1;
		@(posedge CLK);
		ret <= 1'b0;
		repeat (2) @(posedge CLK);
	endtask
	// Pin levels pass a synchroniser, so wait before popping
	task automatic done_isr();
		lvl <= 6'h00;
		repeat (6) @(posedge CLK);
		apb(1'b1, `OFS_FORCE_CLEAR, 32'h0000003F);
		back();
	endtask
	// ==========
	// Main sequence
	initial begin
		// short hold: no clock loop to lock here
		repeat (16) @(posedge CLK);
		RST <= 1'b0;
		repeat (5) @(posedge CLK);
		chk("boot", 32'h0, n_boot);
		BUS_REQUEST_N <= 1'b1;
		// The request pin passes a filter before boot starts
		repeat (8) @(posedge CLK);
		chk("boot", 32'h1, n_boot);
		rd(`OFS_MASK, 32'h0, "mask");
		rd(`OFS_MODE, 32'h0, "mode");
		rd(`OFS_CONTROL, 32'h0, "control");
		apb(1'b1, `OFS_FORCE_CLEAR, 32'h0000003F);
		rd(`OFS_FORCE_CLEAR, 32'h0, "force clear");
		apb(1'b0, 12'h01C, 32'h0);
		chk("slave error", 32'h1, {31'h0, err});
		apb(1'b1, `OFS_MASK, 32'h0000003F);
		for (int k = 0; k < 12; k++) begin
			slow <= (k > 5);
			if (k < 6)
				apb(1'b1, `OFS_FORCE_CLEAR, 32'h100 << k);
			else
				lvl[k - 6] <= 1'b1;
			take_is(14'h0004 + 14'(4 * (k % 6)));
			done_isr();
		end
		apb(1'b1, `OFS_MASK, 32'h0);
		apb(1'b1, `OFS_FORCE_CLEAR, 32'h00002200);
		idle();
		apb(1'b1, `OFS_MASK, 32'h0000003F);
		take_is(14'h0008);
		apb(1'b1, `OFS_MASK, 32'h0);
		apb(1'b1, `OFS_FORCE_CLEAR, 32'h00000002);
		back();
		rd(`OFS_MASK, 32'h3F, "mask");
		take_is(14'h0018);
		apb(1'b1, `OFS_FORCE_CLEAR, 32'h00000200);
		idle();
		apb(1'b1, `OFS_CONTROL, 32'h00000010);
		take_is(14'h0008);
		back();
		done_isr();
		chk("serial out", 32'h0, {31'h0, TX_DATA_B});
		SERIAL_B_ALT <= 1'b1;
		RX_DATA_B <= 1'b1;
		repeat (2) @(posedge CLK);
		chk("flag in", 32'h1, {31'h0, FLAG_INPUT});
		chk("flag out", 32'h1, {31'h0, TX_DATA_B});
		// Ext int zero on edge: a short pulse stays latched while masked
		apb(1'b1, `OFS_CONTROL, 32'h00000011);
		apb(1'b1, `OFS_MASK, 32'h0);
		rfs_n <= 1'b0;
		repeat (6) @(posedge CLK);
		rfs_n <= 1'b1;
		idle();
		apb(1'b1, `OFS_MASK, 32'h0000003F);
		take_is(14'h0014);
		done_isr();
		// Ext int one on level
		tfs_n <= 1'b0;
		take_is(14'h0010);
		tfs_n <= 1'b1;
		done_isr();
		idle();
		end_sim();
	end
endmodule
`default_nettype wire
